// >>> verilog/ccdsp_defs.vh
// Constants for the CCD supply start-up and driver gating block
`ifndef CCDSP_DEFS_VH
`define CCDSP_DEFS_VH
`define CCDSP_ADDR_CTRL0      4'h0
`define CCDSP_ADDR_CTRL1      4'h4
`define CCDSP_ADDR_STATUS     4'h8
`define CCDSP_CTRL0_POWER     0
`define CCDSP_CTRL0_OUT_DIS   1
`define CCDSP_CTRL0_EXT_CLK   3
`define CCDSP_CTRL1_HEADROOM  0
`define CCDSP_CTRL1_MODE2     1
`define CCDSP_CTRL0_RESET     5'h00
`define CCDSP_CTRL1_RESET     2'h0
`define CCDSP_CLK_PERIOD_NS   10
`define CCDSP_OSC_PHASE_NS    500
`define CCDSP_OSC_PHASE_CYC   ((`CCDSP_OSC_PHASE_NS + `CCDSP_CLK_PERIOD_NS \
                                - 1) / `CCDSP_CLK_PERIOD_NS)
`define CCDSP_RESP_OKAY       2'h0
`define CCDSP_RESP_SLVERR     2'h2
`endif

// >>> verilog/ccdsp_top.v
// Supply start-up sequencer, converter phase control and driver gating
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ns
`include "ccdsp_defs.vh"

module ccdsp_top #(
  parameter integer NUM_DRV   = 8,
  parameter integer OSC_PHASE = `CCDSP_OSC_PHASE_CYC
) (
  input  wire               aclk,
  input  wire               aresetn,
  input  wire [3:0]         s_axi_awaddr,
  input  wire               s_axi_awvalid,
  output wire               s_axi_awready,
  input  wire [31:0]        s_axi_wdata,
  input  wire [3:0]         s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output wire               s_axi_wready,
  output reg  [1:0]         s_axi_bresp,
  output reg                s_axi_bvalid,
  input  wire               s_axi_bready,
  input  wire [3:0]         s_axi_araddr,
  input  wire               s_axi_arvalid,
  output wire               s_axi_arready,
  output reg  [31:0]        s_axi_rdata,
  output reg  [1:0]         s_axi_rresp,
  output reg                s_axi_rvalid,
  input  wire               s_axi_rready,
  input  wire               ext_clk_in,
  input  wire               high_rail_full,
  input  wire               high_rail_above80,
  input  wire               driver_rail_full,
  input  wire               driver_supply_above80,
  input  wire               substrate_above80,
  input  wire               base_at_target,
  input  wire               current_limit_pin,
  input  wire [NUM_DRV-1:0] drv_in,
  input  wire               shutter_in,
  output reg  [NUM_DRV-1:0] drv_upper_on,
  output reg  [NUM_DRV-1:0] drv_lower_on,
  output wire [NUM_DRV-1:0] drv_oe,
  output reg                shutter_out,
  output wire               ready_n,
  output wire               supplies_good_internal,
  output reg                coil2_charge_switch,
  output reg                driver_rail_steer_switch,
  output reg                coil1_charge_switch,
  output wire               headroom_double_sel,
  output wire               mode2_sel,
  output wire               amp_min_current_high,
  output wire               amp_max_current_high
);

  localparam [3:0] ST_OFF   = 4'b0001;
  localparam [3:0] ST_HIGH  = 4'b0010;
  localparam [3:0] ST_DRV   = 4'b0100;
  localparam [3:0] ST_READY = 4'b1000;
  localparam integer NSYNC  = 8 + NUM_DRV;
  localparam integer PHASE_LAST = OSC_PHASE - 1;

  reg  [4:0]       ctrl0;
  reg  [1:0]       ctrl1;
  reg  [3:0]       state;
  reg  [3:0]       next_state;
  reg  [NSYNC-1:0] sync1;
  reg  [NSYNC-1:0] sync2;
  reg              ext_prev;
  reg  [15:0]      osc_cnt;
  reg              phase_charge;
  reg              shutter_sync1;
  reg              shutter_sync2;
  reg              aw_held;
  reg              w_held;
  reg  [3:0]       aw_addr;
  reg  [31:0]      w_data;
  reg  [3:0]       w_strb;
  wire [NSYNC-1:0] async_in;
  wire             s_ext;
  wire             s_hfull;
  wire             s_h80;
  wire             s_dfull;
  wire             s_ds80;
  wire             s_sub80;
  wire             s_base;
  wire             s_limit;
  wire [NUM_DRV-1:0] s_drv;
  wire             power_on;
  wire             out_dis;
  wire             ext_sel;
  wire             osc_tick;
  wire             ext_tick;
  wire             conv_tick;
  wire             good;
  wire             drv_en;
  wire             pos_run;
  wire             wr_go;
  wire [31:0]      status;

  function mapped;
    input [3:0] addr;
    begin
      mapped = (addr == `CCDSP_ADDR_CTRL0) || (addr == `CCDSP_ADDR_CTRL1) ||
               (addr == `CCDSP_ADDR_STATUS);
    end
  endfunction

  // Every level from outside this clock domain is double-registered
  assign async_in = {drv_in, current_limit_pin, base_at_target,
                     substrate_above80, driver_supply_above80,
                     driver_rail_full, high_rail_above80,
                     high_rail_full, ext_clk_in};

  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= {NSYNC{1'b0}};
      sync2 <= {NSYNC{1'b0}};
    end else begin
      sync1 <= async_in;
      sync2 <= sync1;
    end
  end

  assign s_ext   = sync2[0];
  assign s_hfull = sync2[1];
  assign s_h80   = sync2[2];
  assign s_dfull = sync2[3];
  assign s_ds80  = sync2[4];
  assign s_sub80 = sync2[5];
  assign s_base  = sync2[6];
  assign s_limit = sync2[7];
  assign s_drv   = sync2[NSYNC-1:8];

  assign power_on = ctrl0[`CCDSP_CTRL0_POWER];
  assign out_dis  = ctrl0[`CCDSP_CTRL0_OUT_DIS];
  assign ext_sel  = ctrl0[`CCDSP_CTRL0_EXT_CLK];
  assign headroom_double_sel = ctrl1[`CCDSP_CTRL1_HEADROOM];
  assign mode2_sel = ctrl1[`CCDSP_CTRL1_MODE2];

  // Converter time base: free oscillator divider or external clock edges
  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_cnt  <= 16'h0000;
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= s_ext;
      if (osc_tick)
        osc_cnt <= 16'h0000;
      else
        osc_cnt <= osc_cnt + 16'h0001;
    end
  end

  assign osc_tick  = ({16'h0000, osc_cnt} == PHASE_LAST);
  assign ext_tick  = s_ext & ~ext_prev;
  assign conv_tick = ext_sel ? ext_tick : osc_tick;

  // Start-up sequencer; power-down parks it and stops the converters
  always @* begin
    next_state = state;
    case (state)
      ST_OFF:
        if (power_on)
          next_state = ST_HIGH;
      ST_HIGH:
        if (s_hfull)
          next_state = ST_DRV;
      ST_DRV:
        if (!s_h80)
          next_state = ST_HIGH;
        else if (s_hfull && s_dfull && s_ds80 && s_sub80)
          next_state = ST_READY;
      ST_READY:
        if (!s_h80 || !s_ds80 || !s_sub80)
          next_state = ST_HIGH;
      default:
        next_state = ST_OFF;
    endcase
    if (!power_on)
      next_state = ST_OFF;
  end

  always @(posedge aclk) begin
    if (!aresetn)
      state <= ST_OFF;
    else
      state <= next_state;
  end

  assign good    = (state == ST_READY);
  assign ready_n = ~good;
  assign supplies_good_internal = ~ready_n;

  // Start-up boost; mode 2 keeps the high ceiling once running
  assign amp_min_current_high = ready_n & ~good & ~s_base;
  assign amp_max_current_high = ready_n | mode2_sel;

  // Positive converter runs only while some capacitor is below target
  assign pos_run = (state != ST_OFF) && (!s_hfull || !s_dfull);

  always @(posedge aclk) begin
    if (!aresetn) begin
      phase_charge             <= 1'b0;
      coil2_charge_switch      <= 1'b0;
      driver_rail_steer_switch <= 1'b0;
      coil1_charge_switch      <= 1'b0;
    end else begin
      if (!power_on) begin
        phase_charge        <= 1'b0;
        coil1_charge_switch <= 1'b0;
      end else if (conv_tick) begin
        phase_charge        <= ~phase_charge;
        coil1_charge_switch <= ~phase_charge;
      end
      if (!pos_run)
        coil2_charge_switch <= 1'b0;
      else if (conv_tick)
        coil2_charge_switch <= ~phase_charge;
      else if (s_limit)
        coil2_charge_switch <= 1'b0;
      // Steering changes only as the coil starts charging, or clears at any phase when pos_run drops,
      // so while the converter runs a dump is never split between the two capacitors
      if (!pos_run)
        driver_rail_steer_switch <= 1'b0;
      else if (conv_tick && !phase_charge)
        driver_rail_steer_switch <= (state == ST_DRV) ||
          ((state == ST_READY) && s_hfull);
    end
  end

  // Line drivers: break before make, gated by supplies good
  assign drv_en = good & ~out_dis;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_DRV; gi = gi + 1) begin : g_drv
      always @(posedge aclk) begin
        if (!aresetn) begin
          drv_upper_on[gi] <= 1'b0;
          drv_lower_on[gi] <= 1'b0;
        end else begin
          drv_upper_on[gi] <= drv_en & ~s_drv[gi] &
                              ~drv_lower_on[gi];
          drv_lower_on[gi] <= drv_en & s_drv[gi] &
                              ~drv_upper_on[gi];
        end
      end
      assign drv_oe[gi] = drv_upper_on[gi] | drv_lower_on[gi];
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn)
      shutter_out <= 1'b1;
    else
      shutter_out <= ~shutter_sync2;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      shutter_sync1 <= 1'b0;
      shutter_sync2 <= 1'b0;
    end else begin
      shutter_sync1 <= shutter_in;
      shutter_sync2 <= shutter_sync1;
    end
  end

  // AXI4-Lite write: address and data taken in either order
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign wr_go = aw_held & w_held;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 4'h0;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CCDSP_RESP_OKAY;
      ctrl0        <= `CCDSP_CTRL0_RESET;
      ctrl1        <= `CCDSP_CTRL1_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr) ? `CCDSP_RESP_OKAY
                                        : `CCDSP_RESP_SLVERR;
        // The fixed bit 4 of the first latch is kept at zero
        if (w_strb[0] && aw_addr == `CCDSP_ADDR_CTRL0)
          ctrl0 <= {1'b0, w_data[3], 1'b0, w_data[1:0]};
        if (w_strb[0] && aw_addr == `CCDSP_ADDR_CTRL1)
          ctrl1 <= w_data[1:0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read
  assign s_axi_arready = ~s_axi_rvalid;
  assign status = {20'h00000, coil2_charge_switch, driver_rail_steer_switch,
                   amp_max_current_high, amp_min_current_high,
                   state, supplies_good_internal, ready_n, 2'h0};

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `CCDSP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? `CCDSP_RESP_OKAY
                                           : `CCDSP_RESP_SLVERR;
      case (s_axi_araddr)
        `CCDSP_ADDR_CTRL0:  s_axi_rdata <= {27'h0, ctrl0};
        `CCDSP_ADDR_CTRL1:  s_axi_rdata <= {30'h0, ctrl1};
        `CCDSP_ADDR_STATUS: s_axi_rdata <= status;
        default:            s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> verification/ccdsp_props.sv
// Concurrent checks on the sequencer and driver ports
`timescale 1ns/1ns
module ccdsp_props #(
  parameter integer NUM_DRV = 8
) (
  input wire               aclk,
  input wire               aresetn,
  input wire               high_rail_full,
  input wire               driver_rail_full,
  input wire               driver_supply_above80,
  input wire               substrate_above80,
  input wire [NUM_DRV-1:0] drv_in,
  input wire               shutter_in,
  input wire [NUM_DRV-1:0] drv_upper_on,
  input wire [NUM_DRV-1:0] drv_lower_on,
  input wire [NUM_DRV-1:0] drv_oe,
  input wire               shutter_out,
  input wire               ready_n,
  input wire               supplies_good_internal,
  input wire               mode2_sel,
  input wire               amp_min_current_high,
  input wire               amp_max_current_high
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Six quiet cycles cover sync latency and break-before-make
  sequence s_in_held;
    ($stable(drv_in) && (&drv_oe))[*6];
  endsequence
  sequence s_sh_high;
    shutter_in[*5];
  endsequence
  sequence s_sh_low;
    (!shutter_in)[*5];
  endsequence
  no_overlap_a: assert property ((drv_upper_on & drv_lower_on) == '0)
    else $error("both transistors on");
  good_inv_a: assert property (supplies_good_internal == !ready_n)
    else $error("supplies good not inverse of ready");
  start_hiz_a: assert property (ready_n ##1 ready_n |-> drv_oe == '0)
    else $error("driver enabled during start-up");
  inv_drive_a: assert property (s_in_held |-> drv_upper_on == ~drv_in)
    else $error("driver does not invert");
  shut_inv_a: assert property (s_sh_high |-> !shutter_out)
    else $error("shutter does not invert");
  shut_low_a: assert property (s_sh_low |-> shutter_out)
    else $error("shutter low input not inverted");
  rdy_cause_a: assert property ($fell(ready_n) |-> high_rail_full &&
    driver_rail_full && driver_supply_above80 && substrate_above80)
    else $error("ready without full rails");
  sag_restart_a: assert property ((!substrate_above80)[*6] |-> ready_n)
    else $error("no restart on sag");
  boost_a: assert property (amp_max_current_high == (ready_n || mode2_sel))
    else $error("amplifier maximum current wrong");
  min_drop_a: assert property (!ready_n |-> !amp_min_current_high)
    else $error("minimum current not restored");
endmodule

// >>> verification/ccdsp_ppg.sv
// Pulse pattern generator model feeding driver and shutter inputs
`timescale 1ns/1ns
module ccdsp_ppg (
  input  wire       aclk,
  input  wire       run,
  output reg  [7:0] drv_in,
  output reg        shutter_in
);
  reg [3:0] cnt = 4'h0;
  initial begin
    drv_in = 8'ha5;
    shutter_in = 1'b1;
  end
  // Idle holds a fixed pattern so levels can be judged
  always @(posedge aclk) begin
    cnt <= cnt + 4'h1;
    if (!run) begin
      drv_in <= 8'ha5;
      shutter_in <= 1'b1;
    end else if (cnt == 4'hf) begin
      drv_in <= {drv_in[6:0], drv_in[7]};
      shutter_in <= ~shutter_in;
    end
  end
endmodule

// >>> verification/ccdsp_tb_top.sv
// Self-checking bench for the supply sequencer block
`timescale 1ns/1ns
`include "ccdsp_defs.vh"
module ccdsp_tb_top;
  logic        aclk = 0, aresetn = 0, ext_clk_in = 0;
  logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_rvalid;
  logic        s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs, ext_div = 0;
  logic        high_rail_full = 0, high_rail_above80 = 0;
  logic        driver_rail_full = 0, driver_supply_above80 = 0;
  logic        substrate_above80 = 0, base_at_target = 0;
  logic        current_limit_pin = 0, ppg_run = 0, ext_run = 0;
  logic [7:0]  drv_in, drv_upper_on, drv_lower_on, drv_oe;
  logic        shutter_in, shutter_out, ready_n, supplies_good_internal;
  logic        coil2_charge_switch, driver_rail_steer_switch;
  logic        coil1_charge_switch, headroom_double_sel, mode2_sel;
  logic        amp_min_current_high, amp_max_current_high;
  integer      error_cnt = 0, cmp_count = 0, cyc = 0;
  ccdsp_top #(.OSC_PHASE(4)) i_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_clk_in,
    .high_rail_full, .high_rail_above80, .driver_rail_full,
    .driver_supply_above80, .substrate_above80, .base_at_target,
    .current_limit_pin, .drv_in, .shutter_in, .drv_upper_on, .drv_lower_on,
    .drv_oe, .shutter_out, .ready_n, .supplies_good_internal,
    .coil2_charge_switch, .driver_rail_steer_switch, .coil1_charge_switch,
    .headroom_double_sel, .mode2_sel, .amp_min_current_high,
    .amp_max_current_high);
  ccdsp_ppg i_ppg (.aclk, .run(ppg_run), .drv_in, .shutter_in);
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (ext_run) ext_div <= ext_div + 2'h1;
    ext_clk_in <= ext_div[1];
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      print_verdict;
    end
  end
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Each ends one edge after lowering ready so a new call never collides
  task wr(input [3:0] a, input [31:0] d);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 0;
        if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 0;
      @(posedge aclk);
    end
  endtask
  task rdr(input [3:0] a);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 0;
      @(posedge aclk);
    end
  endtask
  task wait_rdy(input logic v);
    integer n;
    begin
      n = 0;
      while (ready_n !== v && n < 300) begin
        @(posedge aclk);
        n = n + 1;
      end
      chk("ready_n", v, ready_n);
    end
  endtask
  task tog(input integer n, output integer c);
    logic p;
    begin
      c = 0;
      p = coil1_charge_switch;
      repeat (n) begin
        @(posedge aclk);
        if (coil1_charge_switch !== p) c = c + 1;
        p = coil1_charge_switch;
      end
    end
  endtask
  task hi_cnt(input integer n, output integer c);
    begin
      c = 0;
      repeat (n) begin
        @(posedge aclk);
        if (coil2_charge_switch === 1'b1) c = c + 1;
      end
    end
  endtask
  task t_regs;
    begin
      rdr(`CCDSP_ADDR_CTRL0);
      chk("ctrl0", `CCDSP_CTRL0_RESET, rd);
      rdr(`CCDSP_ADDR_CTRL1);
      chk("ctrl1", `CCDSP_CTRL1_RESET, rd);
      rdr(4'hc);
      chk("rresp", `CCDSP_RESP_SLVERR, rs);
      wr(4'hc, 32'h1);
      chk("bresp", `CCDSP_RESP_SLVERR, rs);
      rdr(`CCDSP_ADDR_STATUS);
      chk("state", 4'h1, rd[7:4]);
    end
  endtask
  task t_start;
    integer c;
    begin
      wr(`CCDSP_ADDR_CTRL0, 32'h1);
      repeat (8) @(posedge aclk);
      rdr(`CCDSP_ADDR_STATUS);
      chk("state", 4'h2, rd[7:4]);
      chk("amp_min", 1, amp_min_current_high);
      chk("oe", 0, drv_oe);
      hi_cnt(40, c);
      chk("coil2_run", 1, c >= 16);
      chk("steer_high", 0, driver_rail_steer_switch);
      current_limit_pin <= 1;
      repeat (4) @(posedge aclk);
      hi_cnt(40, c);
      chk("coil2_limit", 1, c >= 1 && c <= 6);
      current_limit_pin <= 0;
      base_at_target <= 1;
      repeat (4) @(posedge aclk);
      chk("amp_min_base", 0, amp_min_current_high);
      base_at_target <= 0;
      high_rail_full <= 1;
      high_rail_above80 <= 1;
      repeat (8) @(posedge aclk);
      rdr(`CCDSP_ADDR_STATUS);
      chk("state", 4'h4, rd[7:4]);
      chk("ready_n", 1, ready_n);
      repeat (16) @(posedge aclk);
      chk("steer_drv", 1, driver_rail_steer_switch);
      driver_rail_full <= 1;
      driver_supply_above80 <= 1;
      substrate_above80 <= 1;
      wait_rdy(0);
      rdr(`CCDSP_ADDR_STATUS);
      chk("state", 4'h8, rd[7:4]);
      chk("good", 1, supplies_good_internal);
      chk("amp_min", 0, amp_min_current_high);
    end
  endtask
  task t_drv;
    begin
      repeat (8) @(posedge aclk);
      chk("upper", 8'h5a, drv_upper_on);
      chk("lower", 8'ha5, drv_lower_on);
      chk("shutter", 0, shutter_out);
      wr(`CCDSP_ADDR_CTRL0, 32'h3);
      repeat (6) @(posedge aclk);
      chk("oe_dis", 0, drv_oe);
      wr(`CCDSP_ADDR_CTRL0, 32'h1);
      ppg_run <= 1;
      repeat (100) @(posedge aclk);
    end
  endtask
  task t_mode;
    begin
      wr(`CCDSP_ADDR_CTRL1, 32'h3);
      rdr(`CCDSP_ADDR_CTRL1);
      chk("ctrl1", 3, rd);
      chk("headroom", 1, headroom_double_sel);
      chk("mode2", 1, mode2_sel);
      chk("amp_max", 1, amp_max_current_high);
      wr(`CCDSP_ADDR_CTRL1, 32'h1);
      chk("mode2", 0, mode2_sel);
      chk("amp_max", 0, amp_max_current_high);
    end
  endtask
  task t_sag;
    begin
      substrate_above80 <= 0;
      wait_rdy(1);
      rdr(`CCDSP_ADDR_STATUS);
      chk("state_rdy", 0, rd[7]);
      chk("oe", 0, drv_oe);
      substrate_above80 <= 1;
      wait_rdy(0);
    end
  endtask
  task t_conv;
    integer c;
    begin
      tog(40, c);
      chk("coil1_osc", 1, c >= 8);
      wr(`CCDSP_ADDR_CTRL0, 32'h9);
      tog(40, c);
      chk("coil1_still", 0, c);
      ext_run <= 1;
      tog(40, c);
      chk("coil1_ext", 1, c >= 8);
      ext_run <= 0;
      wr(`CCDSP_ADDR_CTRL0, 32'h0);
      repeat (4) @(posedge aclk);
      chk("switches", 0, {coil1_charge_switch, coil2_charge_switch,
        driver_rail_steer_switch});
      chk("ready_n", 1, ready_n);
    end
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_regs;
    t_start;
    t_drv;
    t_mode;
    t_sag;
    t_conv;
    print_verdict;
  end
endmodule
bind ccdsp_top ccdsp_props #(.NUM_DRV(NUM_DRV)) i_props (.aclk, .aresetn,
  .high_rail_full, .driver_rail_full, .driver_supply_above80,
  .substrate_above80, .drv_in, .shutter_in, .drv_upper_on, .drv_lower_on,
  .drv_oe, .shutter_out, .ready_n, .supplies_good_internal, .mode2_sel,
  .amp_min_current_high, .amp_max_current_high);
